//--- core/fcp_cmd_ctrl.sv
/*
 * Control-command interpreter of a floppy controller behind AXI4-Lite.
 * Software writes command bytes to the FIFO word, reads result bytes back,
 * and drives the select pins through the digital output register.
 * Assumes track-0 and write-protect pins asynchronous, ID bytes from a
 * data separator on clk.
 */
`timescale 1ns/1ps
module fcp_cmd_ctrl import fcp_pkg::*; #(
    parameter int STEP_CYC = STEP_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AXI4-Lite register port
    input wire fcp_axi_req_s axi_req,
    output fcp_axi_rsp_s axi_rsp,
    // Drive pins
    input wire logic track0_pin,
    input wire logic write_prot_pin,
    output logic step_q,
    output logic dir_q,
    output logic [1:0] drive_select_q,
    output logic int_pending_q,
    // ID fields from the data separator: c,h,r,n high to low
    input wire logic id_valid,
    input wire logic [31:0] id_bytes
);
    initial begin
        if (STEP_CYC < 1) $error("STEP_CYC must be at least 1");
    end

    localparam int TW = $clog2(STEP_CYC + 1);

    // Register select; 3 means unmapped
    function automatic logic [1:0] reg_sel(input logic [31:0] a);
        unique case (a)
            ADDR_DOR: reg_sel = 2'h0;
            ADDR_MSR: reg_sel = 2'h1;
            ADDR_FIFO: reg_sel = 2'h2;
            default: reg_sel = 2'h3;
        endcase
    endfunction : reg_sel

    // Command byte decode
    function automatic fcp_cmd_e decode(input logic [7:0] b);
        if (b == OP_RECAL) decode = CMD_RECAL;
        else if (b == OP_SNS_INT) decode = CMD_SNS_INT;
        else if (b == OP_SPECIFY) decode = CMD_SPECIFY;
        else if (b == OP_SNS_DRV) decode = CMD_SNS_DRV;
        else if (b == OP_SEEK) decode = CMD_SEEK;
        else if (b == OP_CONFIG) decode = CMD_CONFIG;
        else if ((b & MASK_REL_SEEK) == OP_REL_SEEK) decode = CMD_REL_SEEK;
        else if (b == OP_DUMP) decode = CMD_DUMP;
        else if ((b & MASK_MFM) == OP_READ_ID) decode = CMD_READ_ID;
        else if (b == OP_PERP) decode = CMD_PERP;
        else if ((b & MASK_LOCK) == OP_LOCK) decode = CMD_LOCK;
        else if ((b & MASK_MFM) == OP_FORMAT) decode = CMD_FORMAT;
        else if (b[4:0] == OP_READ || b[4:0] == OP_WRITE) decode = CMD_RDWR;
        else decode = CMD_INVALID;
    endfunction : decode

    // Total command bytes per command
    function automatic logic [3:0] cmd_len(input fcp_cmd_e c);
        unique case (c)
            CMD_SNS_INT, CMD_DUMP, CMD_LOCK, CMD_INVALID: cmd_len = 4'd1;
            CMD_RECAL, CMD_SNS_DRV, CMD_READ_ID, CMD_PERP: cmd_len = 4'd2;
            CMD_SPECIFY, CMD_SEEK, CMD_REL_SEEK: cmd_len = 4'd3;
            CMD_CONFIG: cmd_len = 4'd4;
            CMD_FORMAT: cmd_len = 4'd6;
            CMD_RDWR: cmd_len = PAR_MAX;
        endcase
    endfunction : cmd_len

    // Pin synchronisers: 3 flops, stable once stages 2 and 3 agree
    logic [1:0] pin_in;
    logic [1:0] pin_ok_q;
    assign pin_in = {write_prot_pin, track0_pin};
    for (genvar i = 0; i < 2; i++) begin : g_sync
        logic [2:0] sy_q;
        logic ok_d;
        always_comb begin
            ok_d = (sy_q[1] == sy_q[2]) ? sy_q[2] : pin_ok_q[i];
        end
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                sy_q <= 3'h0;
                pin_ok_q[i] <= 1'b0;
            end else begin
                sy_q <= {sy_q[1:0], pin_in[i]};
                pin_ok_q[i] <= ok_d;
            end
        end
    end

    // Step-rate divider: one-cycle tick every STEP_CYC cycles
    logic [TW-1:0] tmr_q, tmr_d;
    logic tick;
    always_comb begin
        tick = (tmr_q == '0);
        tmr_d = tick ? TW'(STEP_CYC - 1) : tmr_q - 1'b1;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) tmr_q <= '0;
        else tmr_q <= tmr_d;
    end

    // AXI4-Lite channel state
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] awaddr_q, awaddr_d, wdata_q, wdata_d, rdata_q, rdata_d;
    logic wstrb0_q, wstrb0_d;
    logic wr_fire, rd_fire, fifo_wr, fifo_rd;

    // Interpreter state
    fcp_phase_e phase_q, phase_d;
    fcp_cmd_e cmd_q, cmd_d;
    logic [7:0] pbuf_q [PAR_MAX], pbuf_d [PAR_MAX];
    logic [7:0] res_q [RES_MAX], res_d [RES_MAX];
    logic [3:0] pcnt_q, pcnt_d, rcnt_q, rcnt_d, ridx_q, ridx_d;
    logic [7:0] pcn_q [4], pcn_d [4];
    logic [7:0] target_q, target_d, steps_q, steps_d, st0i_q, st0i_d;
    logic [7:0] spec0_q, spec0_d, spec1_q, spec1_d, cfg_q, cfg_d;
    logic [7:0] pretrk_q, pretrk_d, sc_eot_q, sc_eot_d;
    logic [5:0] perp_q, perp_d;
    logic lock_q, lock_d, int_d, step_d, dir_d;
    logic [1:0] dsel_d, drv;
    logic [7:0] msr, st0_hd;

    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    assign rd_fire = axi_req.arvalid && !rvalid_q;
    assign fifo_wr = wr_fire && wstrb0_q && reg_sel(awaddr_q) == 2'h2
                     && phase_q == PH_CMD;
    assign fifo_rd = rd_fire && reg_sel(axi_req.araddr) == 2'h2
                     && phase_q == PH_RES;
    assign drv = pbuf_q[1][1:0];
    assign st0_hd = {5'h0, pbuf_q[1][2:0]};
    assign msr = {phase_q != PH_EXEC, phase_q == PH_RES, 1'b0,
                  phase_q != PH_CMD || pcnt_q != 4'd0, 4'h0};

    // Handshake outputs straight from channel state
    always_comb begin
        axi_rsp.awready = !aw_have_q;
        axi_rsp.wready = !w_have_q;
        axi_rsp.bvalid = bvalid_q;
        axi_rsp.bresp = bresp_q;
        axi_rsp.arready = !rvalid_q;
        axi_rsp.rvalid = rvalid_q;
        axi_rsp.rdata = rdata_q;
        axi_rsp.rresp = rresp_q;
    end

    // Bus channel next state; address and data taken in either order
    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb0_d = wstrb0_q;
        bvalid_d = bvalid_q && !axi_req.bready;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q && !axi_req.rready;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        dsel_d = drive_select_q;
        if (axi_req.awvalid && !aw_have_q) begin
            aw_have_d = 1'b1;
            awaddr_d = axi_req.awaddr;
        end
        if (axi_req.wvalid && !w_have_q) begin
            w_have_d = 1'b1;
            wdata_d = axi_req.wdata;
            wstrb0_d = axi_req.wstrb[0];
        end
        if (wr_fire) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = reg_sel(awaddr_q) == 2'h3 ? RESP_SLVERR : RESP_OKAY;
            if (reg_sel(awaddr_q) == 2'h0 && wstrb0_q) dsel_d = wdata_q[1:0];
        end
        if (rd_fire) begin
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            unique case (reg_sel(axi_req.araddr))
                2'h0: rdata_d = {30'h0, drive_select_q};
                2'h1: rdata_d = {24'h0, msr};
                2'h2: rdata_d = fifo_rd ? {24'h0, res_q[ridx_q]} : 32'h0;
                2'h3: begin
                    rdata_d = 32'h0;
                    rresp_d = RESP_SLVERR;
                end
            endcase
        end
    end

    // Interpreter next state: command, execution and result phases
    always_comb begin
        phase_d = phase_q;
        cmd_d = cmd_q;
        pbuf_d = pbuf_q;
        res_d = res_q;
        pcnt_d = pcnt_q;
        rcnt_d = rcnt_q;
        ridx_d = ridx_q;
        pcn_d = pcn_q;
        target_d = target_q;
        steps_d = steps_q;
        st0i_d = st0i_q;
        spec0_d = spec0_q;
        spec1_d = spec1_q;
        cfg_d = cfg_q;
        pretrk_d = pretrk_q;
        sc_eot_d = sc_eot_q;
        perp_d = perp_q;
        lock_d = lock_q;
        int_d = int_pending_q;
        step_d = 1'b0;
        dir_d = dir_q;
        unique case (phase_q)
            PH_CMD: if (fifo_wr) begin
                pbuf_d[pcnt_q] = wdata_q[7:0];
                if (pcnt_q == 4'd0) cmd_d = decode(wdata_q[7:0]);
                if (pcnt_q + 4'd1 == cmd_len(pcnt_q == 4'd0 ?
                        decode(wdata_q[7:0]) : cmd_q)) begin
                    phase_d = PH_EXEC;
                    pcnt_d = 4'd0;
                    steps_d = 8'h0;
                    // Relative seek target from the offset byte
                    if (!pbuf_q[0][6])
                        target_d = pcn_q[drv] + wdata_q[7:0];
                    else
                        target_d = pcn_q[drv] - wdata_q[7:0];
                    if (cmd_q == CMD_SEEK) target_d = wdata_q[7:0];
                end else begin
                    pcnt_d = pcnt_q + 4'd1;
                end
            end
            PH_EXEC: begin
                phase_d = PH_RES;
                ridx_d = 4'd0;
                unique case (cmd_q)
                    CMD_RECAL: begin
                        phase_d = PH_EXEC;
                        if (pin_ok_q[0]) begin
                            pcn_d[drv] = 8'h0;
                            st0i_d = ST0_SEEK_END | {6'h0, drv};
                            int_d = 1'b1;
                            phase_d = PH_CMD;
                        end else if (steps_q == RECAL_STEPS) begin
                            st0i_d = ST0_RECAL_FAIL | {6'h0, drv};
                            int_d = 1'b1;
                            phase_d = PH_CMD;
                        end else if (tick) begin
                            step_d = 1'b1;
                            dir_d = 1'b0;
                            steps_d = steps_q + 8'd1;
                        end
                    end
                    CMD_SEEK, CMD_REL_SEEK: begin
                        phase_d = PH_EXEC;
                        if (pcn_q[drv] == target_q) begin
                            st0i_d = ST0_SEEK_END | st0_hd;
                            int_d = 1'b1;
                            phase_d = PH_CMD;
                        end else if (tick) begin
                            step_d = 1'b1;
                            dir_d = target_q > pcn_q[drv];
                            pcn_d[drv] = dir_d ? pcn_q[drv] + 8'd1
                                               : pcn_q[drv] - 8'd1;
                        end
                    end
                    CMD_SNS_INT: begin
                        if (int_pending_q) begin
                            res_d[0] = st0i_q;
                            res_d[1] = pcn_q[st0i_q[1:0]];
                            rcnt_d = 4'd2;
                            int_d = 1'b0;
                        end else begin
                            res_d[0] = ST0_INVALID;
                            rcnt_d = 4'd1;
                        end
                    end
                    CMD_SPECIFY: begin
                        spec0_d = pbuf_q[1];
                        spec1_d = pbuf_q[2];
                        phase_d = PH_CMD;
                    end
                    CMD_SNS_DRV: begin
                        res_d[0] = ST3_FIXED | {1'b0, pin_ok_q[1], 1'b0,
                            pin_ok_q[0], 1'b0, pbuf_q[1][2:0]};
                        rcnt_d = 4'd1;
                    end
                    CMD_CONFIG: begin
                        cfg_d = pbuf_q[2];
                        pretrk_d = pbuf_q[3];
                        phase_d = PH_CMD;
                    end
                    CMD_DUMP: begin
                        for (int k = 0; k < 4; k++) res_d[k] = pcn_q[k];
                        res_d[4] = spec0_q;
                        res_d[5] = spec1_q;
                        res_d[6] = sc_eot_q;
                        res_d[7] = {lock_q, 1'b0, perp_q};
                        res_d[8] = cfg_q;
                        res_d[9] = pretrk_q;
                        rcnt_d = RES_MAX;
                    end
                    CMD_READ_ID: begin
                        phase_d = PH_EXEC;
                        if (id_valid) begin
                            res_d[0] = st0_hd;
                            res_d[1] = 8'h0;
                            res_d[2] = 8'h0;
                            for (int k = 0; k < 4; k++)
                                res_d[3 + k] = id_bytes[31 - 8 * k -: 8];
                            rcnt_d = 4'd7;
                            phase_d = PH_RES;
                        end
                    end
                    CMD_PERP: begin
                        perp_d = pbuf_q[1][5:0];
                        phase_d = PH_CMD;
                    end
                    CMD_LOCK: begin
                        lock_d = pbuf_q[0][7];
                        res_d[0] = {3'h0, pbuf_q[0][7], 4'h0};
                        rcnt_d = 4'd1;
                    end
                    CMD_FORMAT, CMD_RDWR: begin
                        // No media engine: parameters recorded, abnormal end
                        sc_eot_d = cmd_q == CMD_FORMAT ? pbuf_q[3]
                                                       : pbuf_q[6];
                        res_d[0] = ST0_ABNORMAL | st0_hd;
                        res_d[1] = 8'h0;
                        res_d[2] = 8'h0;
                        for (int k = 0; k < 4; k++) res_d[3 + k] = pbuf_q[2 + k];
                        rcnt_d = 4'd7;
                    end
                    CMD_INVALID: begin
                        res_d[0] = ST0_INVALID;
                        rcnt_d = 4'd1;
                    end
                endcase
            end
            PH_RES: if (fifo_rd) begin
                ridx_d = ridx_q + 4'd1;
                if (ridx_q + 4'd1 == rcnt_q) phase_d = PH_CMD;
            end
        endcase
    end

    // Register all state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 32'h0;
            wdata_q <= 32'h0;
            wstrb0_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0;
            drive_select_q <= 2'h0;
            phase_q <= PH_CMD;
            cmd_q <= CMD_INVALID;
            pbuf_q <= '{default: 8'h0};
            res_q <= '{default: 8'h0};
            pcnt_q <= 4'd0;
            rcnt_q <= 4'd0;
            ridx_q <= 4'd0;
            pcn_q <= '{default: 8'h0};
            target_q <= 8'h0;
            steps_q <= 8'h0;
            st0i_q <= 8'h0;
            spec0_q <= RST_SPEC0;
            spec1_q <= RST_SPEC0;
            cfg_q <= RST_CFG;
            pretrk_q <= 8'h0;
            sc_eot_q <= 8'h0;
            perp_q <= 6'h0;
            lock_q <= 1'b0;
            int_pending_q <= 1'b0;
            step_q <= 1'b0;
            dir_q <= 1'b0;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb0_q <= wstrb0_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            drive_select_q <= dsel_d;
            phase_q <= phase_d;
            cmd_q <= cmd_d;
            pbuf_q <= pbuf_d;
            res_q <= res_d;
            pcnt_q <= pcnt_d;
            rcnt_q <= rcnt_d;
            ridx_q <= ridx_d;
            pcn_q <= pcn_d;
            target_q <= target_d;
            steps_q <= steps_d;
            st0i_q <= st0i_d;
            spec0_q <= spec0_d;
            spec1_q <= spec1_d;
            cfg_q <= cfg_d;
            pretrk_q <= pretrk_d;
            sc_eot_q <= sc_eot_d;
            perp_q <= perp_d;
            lock_q <= lock_d;
            int_pending_q <= int_d;
            step_q <= step_d;
            dir_q <= dir_d;
        end
    end

    // Checks on the interpreter
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    recal_track0_a: assert property (phase_q == PH_EXEC && cmd_q == CMD_RECAL
        && pin_ok_q[0] |=> int_pending_q && pcn_q[$past(drv)] == 8'h0
        && phase_q == PH_CMD) else $error("recalibrate did not end at zero");
    sense_int_a: assert property (phase_q == PH_EXEC && cmd_q == CMD_SNS_INT
        && int_pending_q |=> phase_q == PH_RES && rcnt_q == 4'd2
        && res_q[0] == $past(st0i_q) && !int_pending_q)
        else $error("sense interrupt result wrong");
    seek_end_a: assert property (phase_q == PH_EXEC && cmd_q == CMD_SEEK
        && pcn_q[drv] == target_q |=> int_pending_q
        && st0i_q[5] && phase_q == PH_CMD) else $error("seek end wrong");
    drive_status_a: assert property (phase_q == PH_EXEC
        && cmd_q == CMD_SNS_DRV |=> phase_q == PH_RES && rcnt_q == 4'd1
        && res_q[0][4] == $past(pin_ok_q[0])) else $error("drive status wrong");
    read_id_a: assert property (phase_q == PH_EXEC && cmd_q == CMD_READ_ID
        && id_valid |=> rcnt_q == 4'd7 && res_q[3] == $past(id_bytes[31:24])
        && res_q[6] == $past(id_bytes[7:0])) else $error("read id capture");
    invalid_code_a: assert property (phase_q == PH_RES
        && cmd_q == CMD_INVALID |-> rcnt_q == 4'd1 && res_q[0] == ST0_INVALID)
        else $error("invalid code result not 80");
    dump_format_a: assert property (phase_q == PH_EXEC
        && cmd_q == CMD_FORMAT |=> sc_eot_q == $past(pbuf_q[3]))
        else $error("format count not kept");
    dump_eot_a: assert property (phase_q == PH_EXEC
        && cmd_q == CMD_RDWR |=> sc_eot_q == $past(pbuf_q[6]))
        else $error("end of track not kept");
    select_pins_a: assert property (!wr_fire
        |=> drive_select_q == $past(drive_select_q))
        else $error("select pins moved without a write");
    phase_hold_a: assert property (phase_q == PH_CMD && !fifo_wr
        |=> phase_q == PH_CMD && pcnt_q == $past(pcnt_q))
        else $error("command phase moved without a byte");
endmodule : fcp_cmd_ctrl

//--- core/fcp_pkg.sv
/*
 * Shared constants and types of the floppy command interpreter: register
 * map, command codes, status codes, timing and the AXI4-Lite carriers.
 * Assumes a 100 MHz system clock and a 32-bit AXI4-Lite master.
 */
package fcp_pkg;
    // Register byte addresses
    localparam logic [31:0] ADDR_DOR = 32'h0000_0000;
    localparam logic [31:0] ADDR_MSR = 32'h0000_0004;
    localparam logic [31:0] ADDR_FIFO = 32'h0000_0008;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Command byte codes and masks
    localparam logic [7:0] OP_RECAL = 8'h07;
    localparam logic [7:0] OP_SNS_INT = 8'h08;
    localparam logic [7:0] OP_SPECIFY = 8'h03;
    localparam logic [7:0] OP_SNS_DRV = 8'h04;
    localparam logic [7:0] OP_SEEK = 8'h0f;
    localparam logic [7:0] OP_CONFIG = 8'h13;
    localparam logic [7:0] OP_REL_SEEK = 8'h8f;
    localparam logic [7:0] MASK_REL_SEEK = 8'hbf;
    localparam logic [7:0] OP_DUMP = 8'h0e;
    localparam logic [7:0] OP_READ_ID = 8'h0a;
    localparam logic [7:0] OP_PERP = 8'h12;
    localparam logic [7:0] OP_LOCK = 8'h14;
    localparam logic [7:0] OP_FORMAT = 8'h0d;
    localparam logic [7:0] MASK_MFM = 8'hbf;
    localparam logic [7:0] MASK_LOCK = 8'h7f;
    localparam logic [4:0] OP_READ = 5'h06;
    localparam logic [4:0] OP_WRITE = 5'h05;
    // Status values
    localparam logic [7:0] ST0_INVALID = 8'h80;
    localparam logic [7:0] ST0_SEEK_END = 8'h20;
    localparam logic [7:0] ST0_RECAL_FAIL = 8'h70;
    localparam logic [7:0] ST0_ABNORMAL = 8'h40;
    localparam logic [7:0] ST3_FIXED = 8'h28;
    localparam logic [7:0] RECAL_STEPS = 8'd80;
    // Reset values
    localparam logic [7:0] RST_SPEC0 = 8'h00;
    localparam logic [7:0] RST_CFG = 8'h20;
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int STEP_TIME_US = 3;
    localparam int STEP_CYCLES = STEP_TIME_US * CLK_MHZ;
    localparam logic [3:0] RES_MAX = 4'd10;
    localparam logic [3:0] PAR_MAX = 4'd9;

    typedef enum logic [3:0] {
        CMD_RECAL, CMD_SNS_INT, CMD_SPECIFY, CMD_SNS_DRV, CMD_SEEK,
        CMD_CONFIG, CMD_REL_SEEK, CMD_DUMP, CMD_READ_ID, CMD_PERP,
        CMD_LOCK, CMD_FORMAT, CMD_RDWR, CMD_INVALID
    } fcp_cmd_e;

    typedef enum logic [1:0] {PH_CMD, PH_EXEC, PH_RES} fcp_phase_e;

    typedef struct packed {
        logic awvalid;
        logic [31:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [31:0] araddr;
        logic rready;
    } fcp_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } fcp_axi_rsp_s;
endpackage : fcp_pkg

//--- tb/fcp_drive_model.sv
/* Drive model: one head position, track-0 sensor, ID strobes.
   Assumes step pulses and direction from the interpreter on clk. */
`timescale 1ns/1ps
module fcp_drive_model (
    // Clock, reset and head motion
    input wire logic clk,
    input wire logic rst,
    input wire logic step_q,
    input wire logic dir_q,
    // Sensor and ID field
    output logic track0_pin,
    output logic id_valid,
    output logic [31:0] id_bytes
);
    logic [7:0] cyl_q;
    logic [3:0] tick_q;
    // Head moves a cylinder per step and stops at 0
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cyl_q <= 8'h03;
            tick_q <= 4'h0;
        end else begin
            tick_q <= tick_q + 4'h1;
            if (step_q && dir_q) cyl_q <= cyl_q + 8'h01;
            else if (step_q && cyl_q != 8'h00) cyl_q <= cyl_q - 8'h01;
        end
    end
    assign track0_pin = (cyl_q == 8'h00);
    assign id_valid = (tick_q == 4'hf);
    // Off-strobe the bus shows the inverse, so stale data never matches
    assign id_bytes = id_valid ? {cyl_q, 24'h000102} : ~{cyl_q, 24'h000102};
endmodule : fcp_drive_model

//--- tb/tb.sv
/* Self-checking bench of the command interpreter over AXI4-Lite.
   Assumes the drive model on the pins and a short step period. */
`timescale 1ns/1ps
module tb import fcp_pkg::*; ;
    logic clk = 0, rst = 1, wp = 0, stp, dir, trk0, idv, intp;
    fcp_axi_req_s req = '0;
    fcp_axi_rsp_s rsp;
    logic [1:0] dsel, ds, dd;
    logic [31:0] idb, v;
    logic [7:0] res [10];
    logic [7:0] new_cylinder_number, eb;
    int err_count = 0, checks = 0, cyc = 0, steps = 0, s0;
    fcp_cmd_ctrl #(.STEP_CYC(4)) fcp_cmd_ctrl_inst (.clk(clk), .rst(rst),
        .axi_req(req), .axi_rsp(rsp), .track0_pin(trk0),
        .write_prot_pin(wp), .step_q(stp), .dir_q(dir),
        .drive_select_q(dsel), .int_pending_q(intp), .id_valid(idv),
        .id_bytes(idb));
    fcp_drive_model fcp_drive_model_inst (.clk(clk), .rst(rst),
        .step_q(stp), .dir_q(dir), .track0_pin(trk0), .id_valid(idv),
        .id_bytes(idb));
    initial forever #5 clk = ~clk;
    // Cycle limit and inward step count
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (stp === 1'b1 && dir === 1'b1) steps <= steps + 1;
        if (cyc == 20000) begin
            err_count++;
            close_out();
        end
    end
    task automatic close_out;
        if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        req.awvalid <= 1;
        req.awaddr <= a;
        req.wvalid <= 1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1;
        do begin
            @(posedge clk);
            if (rsp.awready) req.awvalid <= 0;
            if (rsp.wready) req.wvalid <= 0;
        end while (rsp.bvalid !== 1'b1);
        req.bready <= 0;
    endtask : wr
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk);
        req.arvalid <= 1;
        req.araddr <= a;
        req.rready <= 1;
        do begin
            @(posedge clk);
            if (rsp.arready) req.arvalid <= 0;
        end while (rsp.rvalid !== 1'b1);
        d = rsp.rdata;
        req.rready <= 0;
    endtask : rd
    // Send every byte; if n > 0, wait for the result phase and pop n results
    task automatic cmd(input logic [7:0] b [$], input int n);
        foreach (b[i]) wr(ADDR_FIFO, {24'h0, b[i]});
        if (n > 0) do rd(ADDR_MSR, v); while (v[6] !== 1'b1);
        for (int i = 0; i < n; i++) begin
            rd(ADDR_FIFO, v);
            res[i] = v[7:0];
        end
    endtask : cmd
    // Main sequence
    initial begin
        void'($urandom(74243));
        repeat (2) @(posedge clk);
        rst <= 0;
        rd(ADDR_MSR, v);
        chk(v, 32'h80);
        ds = 2'($urandom);
        dd = ds;
        wp <= 1'($urandom);
        wr(ADDR_DOR, {30'h0, ds});
        cmd('{8'h00}, 1);
        chk(res[0], ST0_INVALID);
        cmd('{OP_RECAL, {6'h0, dd}}, 0);
        while (intp !== 1'b1) @(posedge clk);
        cmd('{OP_SNS_INT}, 2);
        chk({res[0], res[1]}, {ST0_SEEK_END | {6'h0, dd}, 8'h00});
        new_cylinder_number = 8'd1 + 8'($urandom % 12);
        s0 = steps;
        cmd('{OP_SEEK, {6'h0, dd}, new_cylinder_number}, 0);
        while (intp !== 1'b1) @(posedge clk);
        chk(32'(steps - s0), {24'h0, new_cylinder_number});
        cmd('{OP_SNS_INT}, 2);
        chk({res[0], res[1]}, {ST0_SEEK_END | {6'h0, dd}, new_cylinder_number});
        cmd('{OP_SNS_DRV, {5'h1, dd}}, 1);
        chk(res[0], {1'b0, wp, 4'b1011, dd});
        cmd('{OP_READ_ID, {6'h0, dd}}, 7);
        chk({res[3], res[4], res[5], res[6]}, {new_cylinder_number, 24'h000102});
        eb = 8'($urandom);
        cmd('{OP_FORMAT, {6'h0, dd}, 8'h02, eb, 8'h1b, 8'he5}, 7);
        cmd('{OP_DUMP}, 10);
        chk(res[6], eb);
        eb = 8'($urandom);
        cmd('{8'h06, {6'h0, dd}, new_cylinder_number, 8'h0, 8'h1, 8'h2, eb, 8'h1b, 8'hff}, 7);
        cmd('{OP_DUMP}, 10);
        chk({res[dd], res[6]}, {new_cylinder_number, eb});
        // Per-drive bits go in, lock is set, pins must stay put
        eb = 8'($urandom);
        cmd('{OP_PERP, eb}, 0);
        cmd('{OP_LOCK | 8'h80}, 1);
        chk(res[0], 8'h10);
        cmd('{OP_DUMP}, 10);
        chk(res[7], {2'b10, eb[5:0]});
        chk(dsel, ds);
        close_out();
    end
endmodule : tb
